// ==== hw/sram_cycle_pkg.sv ====
package sram_cycle_pkg;

  // ==========================================================
  // Widths
  localparam int DATA_W  = 16;
  localparam int LANES   = 2;
  localparam int LANE_W  = DATA_W / LANES;
  localparam int ADDR_W  = 16;
  localparam int BURST_W = 2;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS        = 10;
  localparam int SLEEP_ENTRY_TCYC     = 2;
  localparam int SLEEP_RECOVERY_TCYC  = 2;
  localparam int SLEEP_ENTRY_NS       = SLEEP_ENTRY_TCYC * CLK_PERIOD_NS;
  localparam int SLEEP_RECOVERY_NS    = SLEEP_RECOVERY_TCYC * CLK_PERIOD_NS;
  // Longest time rounds down, least time rounds up
  localparam int SLEEP_ENTRY_CYCLES   = SLEEP_ENTRY_NS / CLK_PERIOD_NS;
  localparam int SLEEP_RECOVERY_CYCLES =
    (SLEEP_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W = 2;
  localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_LAST =
    WAKE_CNT_W'(SLEEP_RECOVERY_CYCLES - 1);

  // ==========================================================
  // Reset values
  localparam logic [ADDR_W-1:0]  RST_ADDR   = 16'h0000;
  localparam logic [DATA_W-1:0]  RST_DATA   = 16'h0000;
  localparam logic [LANES-1:0]   RST_LANES  = 2'h0;
  localparam logic [BURST_W-1:0] RST_BURST  = 2'h0;
  localparam logic [WAKE_CNT_W-1:0] RST_WAKE = 2'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BURST,
    ST_SNOOZE,
    ST_WAKE
  } ctrl_state_t;

  typedef struct packed {
    logic             global_write_n;
    logic             byte_write_enable_n;
    logic [LANES-1:0] byte_lane_select_n;
  } write_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  write_lanes;
    logic              read;
  } core_req_t;

  typedef struct packed {
    logic [LANES-1:0]  parity;
    logic [DATA_W-1:0] data;
  } word_t;

endpackage

// ==== hw/write_lane_decode.sv ====
`timescale 1ns/100ps
`default_nettype none

module write_lane_decode (
  input  wire sram_cycle_pkg::write_ctrl_t         ctrl,
  output logic [sram_cycle_pkg::LANES-1:0]         lanes
);

  // ==========================================================
  // Per-lane write decode
  genvar i;
  generate
    for (i = 0; i < sram_cycle_pkg::LANES; i++) begin : g_lane
      assign lanes[i] = ~ctrl.global_write_n |
                        (~ctrl.byte_write_enable_n & ~ctrl.byte_lane_select_n[i]);
    end
  endgenerate

endmodule

`default_nettype wire

// ==== hw/burst_address_counter.sv ====
`timescale 1ns/100ps
`default_nettype none

module burst_address_counter (
  input  wire logic                                ref_clk,
  input  wire logic                                rst,
  input  wire logic                                load,
  input  wire logic                                advance,
  input  wire logic [sram_cycle_pkg::BURST_W-1:0]  start_low,
  input  wire logic                                interleaved,
  output logic [sram_cycle_pkg::BURST_W-1:0]       next_low
);

  logic [sram_cycle_pkg::BURST_W-1:0] base;
  logic [sram_cycle_pkg::BURST_W-1:0] count;
  logic [sram_cycle_pkg::BURST_W-1:0] next_count;

  // ==========================================================
  // Count step
  always_comb begin
    if (load) begin
      next_count = sram_cycle_pkg::RST_BURST;
    end else if (advance) begin
      next_count = count + 2'h1;
    end else begin
      next_count = count;
    end
  end

  // ==========================================================
  // Address order
  always_comb begin
    if (load) begin
      next_low = start_low;
    end else if (interleaved) begin
      next_low = base ^ next_count;
    end else begin
      next_low = base + next_count;
    end
  end

  // Wraps within four words, upper bits never carry
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      base  <= sram_cycle_pkg::RST_BURST;
      count <= sram_cycle_pkg::RST_BURST;
    end else begin
      if (load) begin
        base <= start_low;
      end
      count <= next_count;
    end
  end

endmodule

`default_nettype wire

// ==== hw/sync_burst_sram_cycle_control.sv ====
// Behaviour
// - Processor strobe with all chip selects active starts a read burst at external address.
// - Controller strobe alone, chips selected, starts burst; write if write decode says so.
// - No strobe start, advance low, no write: read continues at next burst address.
// - No strobe start, advance low, write indicated: write at next burst address.
// - No strobe start, advance high, no write: read repeats at current address.
// - No strobe start, advance high, write indicated: write at current address.
// - Sleep high puts device in snooze, data pins released, inputs ignored.
// - Snooze entered within two cycles; two cycles recovery after sleep falls. Code: snooze on third edge after sleep rises, idle on fifth after it falls.
// - Processor strobe start is always a read, whatever the write inputs show.
// - Writes only on a controller start edge or in burst cycles after either start.
// - Output enable ignored for the remainder of a write cycle.
// - Output enable gates data drivers asynchronously, not registered.
// - During reads data drives while output enable low, released while high.
// - Once a write is detected every data and parity pin is released.
// - Burst order linear when order input low, interleaved when high.
`timescale 1ns/100ps
`default_nettype none

module sync_burst_sram_cycle_control (
  input  wire logic                                   ref_clk,
  input  wire logic                                   rst,
  input  wire logic                                   chip_select_1_n,
  input  wire logic                                   chip_select_2,
  input  wire logic                                   chip_select_3_n,
  input  wire logic                                   processor_addr_strobe_n,
  input  wire logic                                   controller_addr_strobe_n,
  input  wire logic                                   burst_advance_n,
  input  wire sram_cycle_pkg::write_ctrl_t            write_ctrl,
  input  wire logic                                   output_enable_n,
  input  wire logic                                   sleep_request,
  input  wire logic                                   burst_order,
  input  wire logic [sram_cycle_pkg::ADDR_W-1:0]      addr_in,
  input  wire sram_cycle_pkg::word_t                  pin_in,
  input  wire sram_cycle_pkg::word_t                  core_rdata,
  output var sram_cycle_pkg::core_req_t               core_req,
  output var sram_cycle_pkg::word_t                   core_wdata,
  output var sram_cycle_pkg::word_t                   pin_out,
  output logic [sram_cycle_pkg::DATA_W-1:0]           dq_oe,
  output logic [sram_cycle_pkg::LANES-1:0]            parity_oe,
  output logic                                        snoozing
);

  // ==========================================================
  // Synchronisers for the asynchronous pins
  logic sleep_meta;
  logic sleep_sync;
  logic order_meta;
  logic order_sync;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
    end else begin
      sleep_meta <= sleep_request;
      sleep_sync <= sleep_meta;
    end
  end

  // Resets to interleaved, the order an open pin selects
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      order_meta <= 1'b1;
      order_sync <= 1'b1;
    end else begin
      order_meta <= burst_order;
      order_sync <= order_meta;
    end
  end

  // ==========================================================
  // Control state
  sram_cycle_pkg::ctrl_state_t        state;
  sram_cycle_pkg::ctrl_state_t        next_state;
  logic [sram_cycle_pkg::WAKE_CNT_W-1:0] wake_cnt;
  logic                               active;

  assign active = (state == sram_cycle_pkg::ST_IDLE) ||
                  (state == sram_cycle_pkg::ST_BURST);

  // Sleep stops decoding as soon as the synchroniser shows it
  logic decode_on;
  assign decode_on = active & ~sleep_sync;

  // ==========================================================
  // Cycle decode
  logic [sram_cycle_pkg::LANES-1:0] lanes;
  logic                             write_any;
  logic                             selects_ok;
  logic                             proc_start;
  logic                             ctrl_start;
  logic                             deselect;
  logic                             load;
  logic                             advance;
  logic                             do_read;
  logic                             do_write;

  write_lane_decode u_lane_decode (
    .ctrl  (write_ctrl),
    .lanes (lanes)
  );

  assign write_any  = |lanes;
  assign selects_ok = ~chip_select_1_n & chip_select_2 & ~chip_select_3_n;
  // Processor strobe counts only while chip select 1 is low
  assign proc_start = ~processor_addr_strobe_n & ~chip_select_1_n;
  assign ctrl_start = ~proc_start & ~controller_addr_strobe_n;

  always_comb begin
    deselect = 1'b0;
    load     = 1'b0;
    advance  = 1'b0;
    do_read  = 1'b0;
    do_write = 1'b0;
    if (!decode_on) begin
      deselect = 1'b0;
    end else if (proc_start) begin
      if (selects_ok) begin
        load    = 1'b1;
        do_read = 1'b1;
      end else begin
        deselect = 1'b1;
      end
    end else if (ctrl_start) begin
      if (selects_ok) begin
        load     = 1'b1;
        do_write = write_any;
        do_read  = ~write_any;
      end else begin
        deselect = 1'b1;
      end
    end else if (state == sram_cycle_pkg::ST_BURST) begin
      advance  = ~burst_advance_n;
      do_write = write_any;
      do_read  = ~write_any;
    end
  end

  // ==========================================================
  // State sequence
  always_comb begin
    next_state = state;
    case (state)
      sram_cycle_pkg::ST_IDLE: begin
        if (sleep_sync) begin
          next_state = sram_cycle_pkg::ST_SNOOZE;
        end else if (load) begin
          next_state = sram_cycle_pkg::ST_BURST;
        end
      end
      sram_cycle_pkg::ST_BURST: begin
        if (sleep_sync) begin
          next_state = sram_cycle_pkg::ST_SNOOZE;
        end else if (deselect) begin
          next_state = sram_cycle_pkg::ST_IDLE;
        end
      end
      sram_cycle_pkg::ST_SNOOZE: begin
        if (!sleep_sync) begin
          next_state = sram_cycle_pkg::ST_WAKE;
        end
      end
      sram_cycle_pkg::ST_WAKE: begin
        if (sleep_sync) begin
          next_state = sram_cycle_pkg::ST_SNOOZE;
        end else if (wake_cnt == sram_cycle_pkg::WAKE_CNT_LAST) begin
          next_state = sram_cycle_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = sram_cycle_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= sram_cycle_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Recovery count; pending accesses across sleep are dropped
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wake_cnt <= sram_cycle_pkg::RST_WAKE;
    end else if (state == sram_cycle_pkg::ST_WAKE) begin
      wake_cnt <= wake_cnt + 2'h1;
    end else begin
      wake_cnt <= sram_cycle_pkg::RST_WAKE;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      snoozing <= 1'b0;
    end else begin
      snoozing <= (next_state == sram_cycle_pkg::ST_SNOOZE) ||
                  (next_state == sram_cycle_pkg::ST_WAKE);
    end
  end

  // ==========================================================
  // Burst address
  logic [sram_cycle_pkg::BURST_W-1:0] next_low;
  logic [sram_cycle_pkg::ADDR_W-1:0]  upper_addr;

  burst_address_counter u_counter (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .load        (load),
    .advance     (advance),
    .start_low   (addr_in[sram_cycle_pkg::BURST_W-1:0]),
    .interleaved (order_sync),
    .next_low    (next_low)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upper_addr <= sram_cycle_pkg::RST_ADDR;
    end else if (load) begin
      upper_addr <= addr_in;
    end
  end

  // ==========================================================
  // Core request
  logic [sram_cycle_pkg::ADDR_W-1:0] req_addr;
  logic [sram_cycle_pkg::LANES-1:0]  req_lanes;
  logic                              req_read;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req_addr <= sram_cycle_pkg::RST_ADDR;
    end else if (load) begin
      req_addr <= addr_in;
    end else begin
      req_addr <= {upper_addr[sram_cycle_pkg::ADDR_W-1:sram_cycle_pkg::BURST_W],
                   next_low};
    end
  end

  // Lane and read flags clear on every idle or deselected edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req_lanes <= sram_cycle_pkg::RST_LANES;
    end else begin
      req_lanes <= do_write ? lanes : sram_cycle_pkg::RST_LANES;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req_read <= 1'b0;
    end else begin
      req_read <= do_read;
    end
  end

  assign core_req = {req_addr, req_lanes, req_read};

  // Write data captured on the same edge as the write decode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      core_wdata.parity <= sram_cycle_pkg::RST_LANES;
      core_wdata.data   <= sram_cycle_pkg::RST_DATA;
    end else if (do_write) begin
      core_wdata <= pin_in;
    end
  end

  // ==========================================================
  // Read data path and drivers
  logic read_drive;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_out.parity <= sram_cycle_pkg::RST_LANES;
      pin_out.data   <= sram_cycle_pkg::RST_DATA;
    end else if (core_req.read) begin
      pin_out <= core_rdata;
    end
  end

  // Drivers allowed only in a live read; a write or deselect drops them
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      read_drive <= 1'b0;
    end else begin
      read_drive <= core_req.read & ~do_write & ~deselect & active;
    end
  end

  // Output enable stays combinational so bus release needs no clock
  logic drive;
  assign drive     = read_drive & ~output_enable_n & ~sleep_sync;
  assign dq_oe     = {sram_cycle_pkg::DATA_W{drive}};
  assign parity_oe = {sram_cycle_pkg::LANES{drive}};

endmodule

`default_nettype wire

// ==== verif/sram_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module sram_core_model (
  input  wire sram_cycle_pkg::core_req_t core_req,
  output var  sram_cycle_pkg::word_t     core_rdata
);
  // ==========================================================
  // Array stand-in
  // Address pattern needs no storage; flipped off reads so stale data never matches
  wire sram_cycle_pkg::word_t pat = {core_req.addr[1:0] ^ 2'h3, core_req.addr ^ 16'h5a5a};
  assign core_rdata = core_req.read ? pat : ~pat;
endmodule

`default_nettype wire

// ==== verif/sram_cycle_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none

module sram_cycle_assertions (
  input wire logic                                ref_clk,
  input wire logic                                rst,
  input wire logic                                chip_select_1_n,
  input wire logic                                chip_select_2,
  input wire logic                                chip_select_3_n,
  input wire logic                                processor_addr_strobe_n,
  input wire logic                                controller_addr_strobe_n,
  input wire logic                                burst_advance_n,
  input wire sram_cycle_pkg::write_ctrl_t         write_ctrl,
  input wire logic                                output_enable_n,
  input wire logic                                sleep_request,
  input wire logic [sram_cycle_pkg::ADDR_W-1:0]   addr_in,
  input wire sram_cycle_pkg::word_t               pin_in,
  input wire sram_cycle_pkg::core_req_t           core_req,
  input wire sram_cycle_pkg::word_t               core_wdata,
  input wire logic [sram_cycle_pkg::DATA_W-1:0]   dq_oe,
  input wire logic [sram_cycle_pkg::LANES-1:0]    parity_oe,
  input wire logic                                snoozing
);
  // ==========================================================
  // Cycle decode
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic awake = !sleep_request && !snoozing;
  wire logic sel = awake && chip_select_2 && !chip_select_3_n && !chip_select_1_n;
  wire logic p_go = sel && !processor_addr_strobe_n;
  wire logic c_go = sel && processor_addr_strobe_n && !controller_addr_strobe_n;
  wire logic no_go = controller_addr_strobe_n && (processor_addr_strobe_n || chip_select_1_n);
  wire logic bad = awake && ((chip_select_1_n && !controller_addr_strobe_n) ||
    (!chip_select_1_n && (!chip_select_2 || chip_select_3_n) &&
     !(processor_addr_strobe_n && controller_addr_strobe_n)));

  // ==========================================================
  // Checks
  AST_PROC_READ:
  assert property (p_go |=> core_req.read && core_req.write_lanes == 2'h0 &&
    core_req.addr == $past(addr_in)) else $error("processor start not a read");
  AST_CTRL_WRITE:
  assert property (c_go && !write_ctrl.global_write_n |=> core_req.write_lanes == 2'h3 &&
    !core_req.read && core_wdata == $past(pin_in)) else $error("controller write wrong");
  AST_LANES:
  assert property (c_go && write_ctrl.global_write_n && !write_ctrl.byte_write_enable_n |=>
    core_req.write_lanes == ~$past(write_ctrl.byte_lane_select_n))
    else $error("lane decode wrong");
  AST_DESEL:
  assert property (bad |=> !core_req.read && core_req.write_lanes == 2'h0 ##1 dq_oe == 16'h0)
    else $error("deselect not honoured");
  AST_OE_OFF:
  assert property (output_enable_n |-> dq_oe == 16'h0 && parity_oe == 2'h0)
    else $error("drivers on with output enable high");
  AST_READ_DRV:
  assert property (core_req.read && !bad ##1
    (!output_enable_n && core_req.write_lanes == 2'h0 && awake)
    |-> dq_oe == 16'hffff && parity_oe == 2'h3) else $error("read data not driven");
  AST_WRITE_HIZ:
  assert property (core_req.write_lanes != 2'h0 |-> dq_oe == 16'h0 && parity_oe == 2'h0)
    else $error("pins driven during write");
  AST_SUSPEND:
  assert property (core_req.read && no_go && burst_advance_n && awake &&
    write_ctrl.global_write_n && write_ctrl.byte_write_enable_n |=>
    core_req.read && $stable(core_req.addr)) else $error("suspend moved address");
  AST_SNOOZE_IN:
  assert property ($rose(sleep_request) |-> ##[1:3] snoozing) else $error("snooze late");
  AST_SNOOZE_QUIET:
  assert property (snoozing |-> !core_req.read && core_req.write_lanes == 2'h0 &&
    dq_oe == 16'h0) else $error("activity in snooze");

  cover property (p_go);
  cover property (c_go && !write_ctrl.global_write_n);
  cover property ($rose(snoozing));
endmodule

bind sync_burst_sram_cycle_control sram_cycle_assertions u_chk (
  .ref_clk, .rst, .chip_select_1_n, .chip_select_2, .chip_select_3_n,
  .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n,
  .write_ctrl, .output_enable_n, .sleep_request, .addr_in, .pin_in,
  .core_req, .core_wdata, .dq_oe, .parity_oe, .snoozing
);

`default_nettype wire

// ==== verif/test_sync_burst_sram_cycle_control.sv ====
`timescale 1ns/100ps
`default_nettype none

module test_sync_burst_sram_cycle_control;
  // ==========================================================
  // Signals
  localparam logic [5:0] DES = 6'h35, PS = 6'h13, CS = 6'h15;
  localparam logic [5:0] CONT = 6'h36, SUSP = 6'h37, IDLE = 6'h2f;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic chip_select_1_n = 1'h1;
  logic chip_select_2 = 1'h1;
  logic chip_select_3_n = 1'h0;
  logic processor_addr_strobe_n = 1'h1;
  logic controller_addr_strobe_n = 1'h1;
  logic burst_advance_n = 1'h1;
  sram_cycle_pkg::write_ctrl_t write_ctrl = 4'hf;
  logic output_enable_n = 1'h1;
  logic sleep_request = 1'h0;
  logic burst_order = 1'h1; // Left open: pull-up
  logic [15:0] addr_in = 16'h0;
  sram_cycle_pkg::word_t pin_in = 18'h0;
  sram_cycle_pkg::word_t core_rdata;
  sram_cycle_pkg::core_req_t core_req;
  sram_cycle_pkg::word_t core_wdata;
  sram_cycle_pkg::word_t pin_out;
  logic [15:0] dq_oe;
  logic [1:0] parity_oe;
  logic snoozing;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;

  sync_burst_sram_cycle_control DUT (.ref_clk, .rst, .chip_select_1_n, .chip_select_2,
    .chip_select_3_n, .processor_addr_strobe_n, .controller_addr_strobe_n,
    .burst_advance_n, .write_ctrl, .output_enable_n, .sleep_request, .burst_order,
    .addr_in, .pin_in, .core_rdata, .core_req, .core_wdata, .pin_out, .dq_oe,
    .parity_oe, .snoozing);
  sram_core_model mem (.core_req, .core_rdata);

  always #5 ref_clk = ~ref_clk;

  // ==========================================================
  // Helpers
  task automatic give_verdict();
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_req(input sram_cycle_pkg::core_req_t got, exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: request %h not %h", $time, got, exp);
    end
  endtask

  task automatic chk_v(input logic [17:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: pins %h not %h", $time, got, exp);
    end
  endtask

  // Inputs change at the falling edge; outputs read just after the rising one
  task automatic go(input logic o, input logic [5:0] c, input logic [3:0] w,
                    input logic [15:0] a);
    @(negedge ref_clk);
    output_enable_n = o;
    {chip_select_1_n, chip_select_2, chip_select_3_n, processor_addr_strobe_n,
     controller_addr_strobe_n, burst_advance_n} = c;
    write_ctrl = w;
    addr_in = a;
    pin_in = {a[1:0], ~a};
    @(posedge ref_clk);
    #1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_read();
    burst_order = 1'h0;
    repeat (3) go(1'h1, DES, 4'hf, 16'h0);
    go(1'h0, PS, 4'h7, 16'h1235);
    chk_req(core_req, {16'h1235, 3'h1});
    go(1'h0, CONT, 4'hf, 16'h0);
    chk_req(core_req, {16'h1236, 3'h1});
    chk_v(pin_out, {2'h2, 16'h486f});
    chk_v({dq_oe, parity_oe}, 18'h3ffff);
    @(negedge ref_clk);
    output_enable_n = 1'h1;
    #1;
    chk_v({dq_oe, parity_oe}, 18'h0);
    go(1'h1, CONT, 4'hf, 16'h0);
    chk_req(core_req, {16'h1234, 3'h1});
    go(1'h1, SUSP, 4'hf, 16'h0);
    chk_req(core_req, {16'h1234, 3'h1});
  endtask

  task automatic t_inter();
    @(negedge ref_clk);
    burst_order = 1'h1;
    repeat (3) go(1'h1, DES, 4'hf, 16'h0);
    go(1'h0, CS, 4'hf, 16'h00a2);
    chk_req(core_req, {16'h00a2, 3'h1});
    for (int i = 1; i < 4; i++) begin
      go(1'h0, CONT, 4'hf, 16'h0);
      chk_req(core_req, {16'h00a2 ^ 16'(i), 3'h1});
    end
  endtask

  task automatic t_write();
    logic [3:0] w;
    go(1'h1, CS, 4'h7, 16'h4000); // Enable released first
    chk_req(core_req, {16'h4000, 3'h6});
    chk_v(core_wdata, {2'h0, 16'hbfff});
    chk_v({dq_oe, parity_oe}, 18'h0);
    go(1'h0, CONT, 4'ha, 16'h1234);
    chk_req(core_req, {16'h4001, 3'h2});
    chk_v(core_wdata, {2'h0, 16'hedcb});
    chk_v({dq_oe, parity_oe}, 18'h0);
    go(1'h0, SUSP, 4'h9, 16'h0);
    chk_req(core_req, {16'h4001, 3'h4});
    for (int i = 0; i < 5; i++) begin
      w = (i == 4) ? 4'hc : {2'h2, 2'(i)};
      go(1'h1, CS, w, 16'h0100);
      chk_req(core_req, {16'h0100, (i == 4) ? 2'h0 : ~2'(i), 1'(i >= 3)});
    end
  endtask

  task automatic t_desel();
    logic [5:0] bad [4] = '{6'h35, 6'h03, 6'h1b, 6'h05};
    for (int i = 0; i < 4; i++) begin
      go(1'h0, PS, 4'hf, 16'h0200);
      go(1'h0, bad[i], 4'h7, 16'h0300);
      chk_v({15'h0, core_req.write_lanes, core_req.read}, 18'h0);
      go(1'h0, SUSP, 4'hf, 16'h0);
      chk_v({dq_oe, parity_oe}, 18'h0);
      chk_v({15'h0, core_req.write_lanes, core_req.read}, 18'h0);
    end
  endtask

  task automatic t_sleep();
    int n;
    go(1'h1, DES, 4'hf, 16'h0); // Deselected before sleep
    @(negedge ref_clk);
    sleep_request = 1'h1;
    repeat (2) go(1'h0, IDLE, 4'hf, 16'h0);
    chk_v(18'(snoozing), 18'h1);
    go(1'h0, PS, 4'hf, 16'h0500);
    chk_v({15'h0, core_req.write_lanes, core_req.read}, 18'h0);
    go(1'h0, IDLE, 4'hf, 16'h0);
    chk_v({dq_oe, parity_oe}, 18'h0);
    @(negedge ref_clk);
    sleep_request = 1'h0;
    // Bounded wait; selects stay idle meanwhile
    for (n = 0; n < 8 && snoozing !== 1'h0; n++) go(1'h1, IDLE, 4'hf, 16'h0);
    chk_v(18'(snoozing), 18'h0);
    go(1'h0, PS, 4'hf, 16'h0501);
    chk_req(core_req, {16'h0501, 3'h1});
  endtask

  // ==========================================================
  // Run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'h0;
    t_read();
    t_inter();
    t_write();
    t_desel();
    t_sleep();
    give_verdict();
  end
endmodule

`default_nettype wire
